// ===== core/dms_params.svh
// Constants for the device mode select decode block
`ifndef DMS_PARAMS_SVH
`define DMS_PARAMS_SVH
`define DMS_ADDR_CTRL      8'h00
`define DMS_ADDR_STATUS    8'h04
`define DMS_ADDR_PMDATA    8'h08
`define DMS_ADDR_SUBSYS    8'h0C
`define DMS_ADDR_WAKE      8'h10
`define DMS_ADDR_ACCESS    8'h14
`define DMS_CTRL_F0_PS_LSB 0
`define DMS_CTRL_F1_PS_LSB 2
`define DMS_CTRL_UBAR_BIT  4
`define DMS_CTRL_PMEEN_BIT 5
`define DMS_CTRL_RST       32'h0000_0000
`define DMS_PMDATA_RST     32'h0000_0000
`define DMS_PM_REV_11      3'h2
`define DMS_EE_ZONES_BASE  3'h4
`define DMS_EE_ZONES_ENH   3'h6
`define DMS_WR_WAIT        2'h0
`define DMS_RD_WAIT        2'h1
`define DMS_RD_CLKS        3'h5
`define DMS_WR_CLKS        3'h4
`define DMS_EE_LIMIT_DEF   16
`define DMS_RESP_OKAY      2'h0
`define DMS_RESP_SLVERR    2'h2
`endif

// ===== core/dms_pkg.sv
// Types for the device mode select decode block
package dms_pkg;
  typedef enum logic [2:0] {
    DMS_M_LB   = 3'b000,
    DMS_M_PP   = 3'b001,
    DMS_M_SSID = 3'b010,
    DMS_M_UBAR = 3'b011,
    DMS_M_ELB  = 3'b100,
    DMS_M_EPP  = 3'b101,
    DMS_M_TEST = 3'b110,
    DMS_M_SA   = 3'b111
  } dms_mode_t;
  typedef enum logic [1:0] {
    DMS_F1_LB   = 2'b00,
    DMS_F1_PP   = 2'b01,
    DMS_F1_NONE = 2'b10
  } dms_f1_t;
  typedef enum logic [1:0] {
    DMS_D0 = 2'b00,
    DMS_D1 = 2'b01,
    DMS_D2 = 2'b10,
    DMS_D3 = 2'b11
  } dms_pstate_t;
  typedef enum logic [1:0] {
    DMS_EE_IDLE = 2'b00,
    DMS_EE_LOAD = 2'b01,
    DMS_EE_DONE = 2'b10,
    DMS_EE_OVR  = 2'b11
  } dms_ee_t;
endpackage : dms_pkg

// ===== core/dms_ee_guard.sv
// EEPROM loader overrun guard
`timescale 1ns/10ps
`include "dms_params.svh"
module dms_ee_guard
  import dms_pkg::*;
#(
  parameter int LIMIT = `DMS_EE_LIMIT_DEF
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic       word_valid,
  input  wire logic       word_last,
  input  wire logic       enhanced,
  input  wire logic [2:0] zone,
  output logic            busy,
  output logic            overrun,
  output logic            zone_bad
);
  // Counter is 16 bits wide and needs room for at least two words
  if (LIMIT < 2 || LIMIT > 65535) begin : g_limit_bad
    $error("dms_ee_guard: LIMIT out of range");
  end

  dms_ee_t     st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic        zb_q, zb_d;
  logic [2:0]  zmax;

  always_comb begin
    zmax  = enhanced ? `DMS_EE_ZONES_ENH : `DMS_EE_ZONES_BASE;
    st_d  = st_q;
    cnt_d = cnt_q;
    zb_d  = zb_q;
    case (st_q)
      DMS_EE_IDLE: begin
        if (start) begin
          st_d  = DMS_EE_LOAD;
          cnt_d = 16'h0000;
          zb_d  = 1'b0;
        end
      end
      DMS_EE_LOAD: begin
        if (word_valid) begin
          cnt_d = cnt_q + 16'h0001;
          if (zone >= zmax) zb_d = 1'b1;
          if (word_last) st_d = DMS_EE_DONE;
          else if (cnt_q == 16'(LIMIT - 1)) st_d = DMS_EE_OVR;
        end
      end
      default: begin
        st_d = st_q;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= DMS_EE_IDLE;
      cnt_q <= 16'h0000;
      zb_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      zb_q  <= zb_d;
    end
  end

  assign busy     = (st_q == DMS_EE_LOAD);
  assign overrun  = (st_q == DMS_EE_OVR);
  assign zone_bad = zb_q;
endmodule : dms_ee_guard

// ===== core/dms_mode_decode.sv
// Strap decode, power management and register slave for the mode select block
`timescale 1ns/10ps
`include "dms_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Straps 000, 001, 010 are compatible; function 1 is bus, port, or absent.
// - Straps 011, 100, 101 are enhanced; function 1 bus, bus, port.
// - Strap 111 is standalone with no PCI; 110 is a reserved test mode.
// - Strap 011 or loaded field gives each channel its own I/O base.
// - Enhanced: pin 11 selects PCI or mini-PCI; pins 10..0 stay general.
// - Enhanced: all interrupts of both functions go out on INTA by default.
// - Enhanced with mini-PCI: INTB becomes CLKRUN; PCI leaves INTB unused.
// - Mini-PCI: wake allowed from D3cold, wake context held across it.
// - Channel writes take no wait state, reads exactly one.
// - Channel read done within five clocks, write within four.
// - Function 0 in D3 stops the channel clock.
// - Wake: ring in D3 or modem/serial in D2; function 1 on io 2.
// - Loader stops on overrun so configuration never hangs.
// - Enhanced: power management reports revision 1.1.
// - Enhanced: data and data-scale fields return user values.
// - Enhanced: loader accepts two extra zones.
// - Strap 010 takes subsystem identifiers from pins.
// - Standalone: interrupt pin drives channel interrupt push-pull.
module dms_mode_decode
  import dms_pkg::*;
#(
  parameter int EE_LIMIT = `DMS_EE_LIMIT_DEF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [2:0]  mode_pins,
  input  wire logic        multi_purpose_io_in,
  input  wire logic [3:0]  ring_n,
  input  wire logic [3:0]  modem_n,
  input  wire logic [3:0]  serial_input_line,
  input  wire logic        io2_in,
  input  wire logic [31:0] subsys_pins,
  input  wire logic        f0_irq,
  input  wire logic        f1_irq,
  input  wire logic        d3cold,
  input  wire logic        ee_start,
  input  wire logic        ee_word_valid,
  input  wire logic        ee_word_last,
  input  wire logic [2:0]  ee_zone,
  input  wire logic        ee_ubar_field,
  output logic [2:0]       mode,
  output logic             enhanced,
  output logic             standalone,
  output logic [1:0]       f1_kind,
  output logic             unique_bars,
  output logic             io11_is_select,
  output logic             inta_out,
  output logic             inta_oe,
  output logic             intb_oe,
  output logic             clkrun_en,
  output logic             pme_oe,
  output logic             ch_clk_en,
  output logic [2:0]       pm_version,
  output logic             ee_busy,
  output logic             ee_overrun,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  if (EE_LIMIT < 2 || EE_LIMIT > 65535) begin : g_limit_bad
    $error("dms_mode_decode: EE_LIMIT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture
  logic [2:0] mode_q, mode_d;
  logic       msel_q, msel_d;
  logic       enh, mini;

  always_comb begin
    mode_d = aresetn ? mode_q : mode_pins;
    msel_d = aresetn ? msel_q : multi_purpose_io_in;
  end

  always_ff @(posedge aclk) begin
    mode_q <= mode_d;
    msel_q <= msel_d;
  end

  assign mode        = mode_q;
  assign enh         = (mode_q == DMS_M_UBAR) || (mode_q == DMS_M_ELB)
                    || (mode_q == DMS_M_EPP);
  assign enhanced    = enh;
  assign standalone  = (mode_q == DMS_M_SA);
  assign mini        = enh && msel_q;
  assign io11_is_select = enh;

  always_comb begin
    case (mode_q)
      DMS_M_LB, DMS_M_UBAR, DMS_M_ELB: f1_kind = DMS_F1_LB;
      DMS_M_PP, DMS_M_EPP:             f1_kind = DMS_F1_PP;
      default:                         f1_kind = DMS_F1_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] pmd_q, pmd_d;
  logic        wake_q, wake_d;
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [1:0]  f0_ps, f1_ps;
  logic        wake_ev, wr_go, rd_go, ee_zb;
  logic [31:0] rdv;
  logic [1:0]  rsp;

  assign f0_ps = ctrl_q[`DMS_CTRL_F0_PS_LSB +: 2];
  assign f1_ps = ctrl_q[`DMS_CTRL_F1_PS_LSB +: 2];
  assign unique_bars = (mode_q == DMS_M_UBAR) || ee_ubar_field
                    || ctrl_q[`DMS_CTRL_UBAR_BIT];
  assign ch_clk_en  = (f0_ps != DMS_D3);
  assign pm_version = enh ? `DMS_PM_REV_11 : 3'h1;

  // Wake sources by power state of each function
  assign wake_ev = ((f0_ps == DMS_D3) && (ring_n != 4'hF))
                || ((f0_ps == DMS_D2) && ((modem_n != 4'hF)
                    || (serial_input_line != 4'hF)))
                || ((f1_ps != DMS_D0) && io2_in);

  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    b_d   = b_q;
    br_d  = br_q;
    ctrl_d = ctrl_q;
    pmd_d  = pmd_q;
    wake_d = wake_q;
    if (s_axi_awvalid && !aw_q && !b_q) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !b_q) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) b_d = 1'b0;
    wr_go = aw_q && w_q;
    if (wr_go) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = `DMS_RESP_OKAY;
      if (awa_q == `DMS_ADDR_CTRL) begin
        ctrl_d = wd_q;
      end else if (awa_q == `DMS_ADDR_PMDATA) begin
        if (enh) pmd_d = wd_q;
      end else if (awa_q == `DMS_ADDR_WAKE) begin
        if (wd_q[0]) wake_d = 1'b0;
      end else begin
        br_d = `DMS_RESP_SLVERR;
      end
    end
    // Wake flag: a new event beats a clear in the same cycle
    if (wake_ev && ctrl_q[`DMS_CTRL_PMEEN_BIT]) wake_d = 1'b1;
    // D3cold keeps the flag only for mini-PCI
    if (d3cold && !mini) wake_d = 1'b0;
  end

  always_comb begin
    rdv = 32'h0000_0000;
    rsp = `DMS_RESP_OKAY;
    if (s_axi_araddr == `DMS_ADDR_CTRL) begin
      rdv = ctrl_q;
    end else if (s_axi_araddr == `DMS_ADDR_STATUS) begin
      rdv = {16'h0000, 1'b0, pm_version, 1'b0, ee_zb, ee_overrun, ee_busy,
             clkrun_en, unique_bars, mini, standalone, enh, mode_q};
    end else if (s_axi_araddr == `DMS_ADDR_PMDATA) begin
      rdv = enh ? pmd_q : 32'h0000_0000;
    end else if (s_axi_araddr == `DMS_ADDR_SUBSYS) begin
      rdv = (mode_q == DMS_M_SSID) ? subsys_pins : 32'h0000_0000;
    end else if (s_axi_araddr == `DMS_ADDR_WAKE) begin
      rdv = {31'h0000_0000, wake_q};
    end else if (s_axi_araddr == `DMS_ADDR_ACCESS) begin
      rdv = {8'h00, 5'h00, `DMS_RD_CLKS, 5'h00, `DMS_WR_CLKS,
             2'h0, `DMS_RD_WAIT, 2'h0, `DMS_WR_WAIT};
    end else begin
      rsp = `DMS_RESP_SLVERR;
    end
    rd_go = s_axi_arvalid && !r_q;
    r_d   = r_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (r_q && s_axi_rready) r_d = 1'b0;
    if (rd_go) begin
      r_d  = 1'b1;
      rd_d = rdv;
      rr_d = rsp;
    end
  end

  // Write side state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `DMS_CTRL_RST;
      pmd_q  <= `DMS_PMDATA_RST;
      wake_q <= 1'b0;
      aw_q   <= 1'b0;
      w_q    <= 1'b0;
      b_q    <= 1'b0;
      awa_q  <= 8'h00;
      wd_q   <= 32'h0000_0000;
      br_q   <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      pmd_q  <= pmd_d;
      wake_q <= wake_d;
      aw_q   <= aw_d;
      w_q    <= w_d;
      b_q    <= b_d;
      awa_q  <= awa_d;
      wd_q   <= wd_d;
      br_q   <= br_d;
    end
  end

  // Read side kept apart so a stalled answer never holds up writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q  <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'h0;
    end else begin
      r_q  <= r_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end
  end

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready  = !w_q && !b_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign inta_out  = standalone ? f0_irq : 1'b0;
  assign inta_oe   = standalone ? 1'b1 : (f0_irq || (enh && f1_irq));
  assign intb_oe   = !enh && !standalone && (mode_q != DMS_M_TEST)
                  && f1_irq;
  assign clkrun_en = mini;
  // Standalone relies on the board holding PCI inputs idle
  assign pme_oe    = wake_q && !standalone;

  dms_ee_guard #(
    .LIMIT(EE_LIMIT)
  ) u_guard (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .start      (ee_start),
    .word_valid (ee_word_valid),
    .word_last  (ee_word_last),
    .enhanced   (enh),
    .zone       (ee_zone),
    .busy       (ee_busy),
    .overrun    (ee_overrun),
    .zone_bad   (ee_zb)
  );
endmodule : dms_mode_decode

// ===== bench/dms_ee_model.sv
// EEPROM word source feeding the loader guard
`timescale 1ns/10ps
module dms_ee_model (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [4:0] n_words,
  input  wire logic       with_last,
  output logic            start,
  output logic            word_valid,
  output logic            word_last
);
  logic [4:0] left_q  = 5'h00;
  logic       start_q = 1'h0;
  logic       valid_q = 1'h0;
  logic       last_q  = 1'h0;
  // Words follow the start pulse one per clock, as a fast part would send them
  always @(posedge aclk) begin
    start_q <= go;
    valid_q <= left_q != 5'h00;
    last_q  <= with_last && left_q == 5'h01;
    left_q  <= go ? n_words : (left_q != 5'h00 ? left_q - 5'h01 : 5'h00);
  end
  assign start      = start_q;
  assign word_valid = valid_q;
  assign word_last  = last_q;
endmodule : dms_ee_model

// ===== bench/dms_mode_decode_props.sv
// Checker for the mode select decode ports
`timescale 1ns/10ps
module dms_mode_decode_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [2:0]  mode,
  input wire logic        enhanced,
  input wire logic        standalone,
  input wire logic [1:0]  f1_kind,
  input wire logic        unique_bars,
  input wire logic        io11_is_select,
  input wire logic        inta_out,
  input wire logic        inta_oe,
  input wire logic        clkrun_en,
  input wire logic        f0_irq,
  input wire logic        f1_irq,
  input wire logic [2:0]  pm_version,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence rd_wait; s_axi_rvalid && !s_axi_rready; endsequence
  AST_ENH: assert property (enhanced == (mode inside {3'h3, 3'h4, 3'h5}))
    else $error("enhanced flag wrong");
  AST_SA: assert property (standalone == (mode == 3'h7))
    else $error("standalone flag wrong");
  AST_F1: assert property ((mode == 3'h1 || mode == 3'h5) |-> f1_kind == 2'h1)
    else $error("function 1 kind wrong");
  AST_UBAR: assert property (mode == 3'h3 |-> unique_bars)
    else $error("unique bars missing");
  AST_IO11: assert property (io11_is_select == enhanced)
    else $error("io 11 reuse wrong");
  AST_CLKRUN: assert property (clkrun_en |-> enhanced)
    else $error("clock run outside enhanced");
  AST_HOLD: assert property ($past(aresetn) |-> $stable(mode))
    else $error("mode moved after reset");
  AST_INTA_SA: assert property (standalone && $stable(f0_irq) |->
    inta_oe && inta_out == f0_irq)
    else $error("standalone interrupt wrong");
  AST_INTA_EN: assert property (enhanced && f1_irq && $past(f1_irq) |-> inta_oe)
    else $error("function 1 not on shared line");
  AST_PMREV: assert property (enhanced |-> pm_version == 3'h2)
    else $error("power management revision wrong");
  AST_RD_ANS: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : dms_mode_decode_props
bind dms_mode_decode dms_mode_decode_props dms_mode_decode_props_i (.*);

// ===== bench/tb.sv
// Self-checking bench for the mode select decode block
`timescale 1ns/10ps
`include "dms_params.svh"
module tb;
  import dms_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, multi_purpose_io_in = 1'h0, io2_in = 1'h0;
  logic f0_irq = 1'h0, f1_irq = 1'h0, d3cold = 1'h0, ee_ubar_field = 1'h0, go = 1'h0;
  logic ee_with_last = 1'h0;
  logic [2:0] mode_pins = 3'h0, ee_zone = 3'h0, mode, pm_version;
  logic [3:0] ring_n = 4'hF, modem_n = 4'hF, serial_input_line = 4'hF, s_axi_wstrb = 4'hF;
  logic [31:0] subsys_pins = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ee_start, ee_word_valid, ee_word_last;
  logic enhanced, standalone, unique_bars, io11_is_select, inta_out, inta_oe, intb_oe;
  logic clkrun_en, pme_oe, ch_clk_en, ee_busy, ee_overrun, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] f1_kind, s_axi_bresp, s_axi_rresp;
  int miscompares = 0, check_count = 0;
  // Short loader limit keeps the overrun case brief
  dms_mode_decode #(.EE_LIMIT(4)) dms_mode_decode_i (.*);
  dms_ee_model dms_ee_model_i (.aclk(aclk), .go(go), .n_words(5'h4), .with_last(ee_with_last),
    .start(ee_start), .word_valid(ee_word_valid), .word_last(ee_word_last));
  always #25 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic rst_to(input logic [2:0] m, input logic mini);
    aresetn <= 1'h0;
    mode_pins <= m;
    multi_purpose_io_in <= mini;
    tick(5);
    aresetn <= 1'h1;
    tick(2);
  endtask : rst_to
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_bready <= 1'h1;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!b) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
      // Ready stays up, so back-to-back calls never drive it twice in one step
      if (!aw && !w && s_axi_bvalid) b = 1'h1;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, done;
    ar = 1'h1;
    done = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin
        ar = 1'h0;
        s_axi_arvalid <= 1'h0;
      end
      if (!ar && s_axi_rvalid) begin
        done = 1'h1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
  endtask : rd
  // Read with the answer held off for a few cycles
  task automatic rd_stall(input logic [7:0] a, output logic [31:0] d);
    s_axi_rready <= 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    tick(3);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
  endtask : rd_stall
  ////////////////////////////////////////
  task automatic t_modes;
    logic [2:0] m; logic en; logic [31:0] st; logic [1:0] r;
    logic [1:0] f1x;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      en = m inside {3'h3, 3'h4, 3'h5};
      if (m == 3'h6) continue; // Reserved test strap is never fitted
      rst_to(m, 1'h1);
      chk("enhanced", enhanced, en);
      chk("standalone", standalone, m == 3'h7);
      chk("io11", io11_is_select, en);
      chk("clkrun", clkrun_en, en);
      chk("pmrev", pm_version, en ? `DMS_PM_REV_11 : 3'h1);
      chk("ubar", unique_bars, m == 3'h3);
      f1x = (m == 3'h1 || m == 3'h5) ? 2'h1 : 2'h0;
      if (m == 3'h2) f1x = 2'h2;
      if (m != 3'h7) chk("f1", f1_kind, f1x);
      rd(`DMS_ADDR_STATUS, st, r);
      chk("st_mode", st[2:0], m);
    end
  endtask : t_modes
  task automatic t_hold_irq;
    rst_to(3'h4, 1'h0);
    mode_pins <= 3'h7; multi_purpose_io_in <= 1'h1; f1_irq <= 1'h1;
    tick(3);
    chk("held", {mode, clkrun_en}, {3'h4, 1'h0});
    chk("inta_f1", inta_oe, 1'h1);
    chk("intb", intb_oe, 1'h0);
    f1_irq <= 1'h0; // PCI side held idle for standalone
    rst_to(3'h7, 1'h0);
    f0_irq <= 1'h1;
    tick(2);
    chk("sa_int", {inta_oe, inta_out}, 2'h3);
    f0_irq <= 1'h0;
    tick(2);
    chk("sa_int0", {inta_oe, inta_out}, 2'h2);
  endtask : t_hold_irq
  task automatic t_pm;
    logic [31:0] d; logic [1:0] r;
    rst_to(3'h5, 1'h0);
    wr(`DMS_ADDR_CTRL, 32'h3);
    tick(2);
    chk("clk_d3", ch_clk_en, 1'h0);
    wr(`DMS_ADDR_CTRL, 32'h22);
    modem_n <= 4'hE;
    tick(3);
    chk("wake_d2", pme_oe, 1'h1);
    wr(`DMS_ADDR_WAKE, 32'h1);
    chk("wake_set_wins", pme_oe, 1'h1);
    modem_n <= 4'hF;
    wr(`DMS_ADDR_WAKE, 32'h1);
    tick(2);
    chk("wake_clr", {pme_oe, ch_clk_en}, 2'h1);
    wr(`DMS_ADDR_CTRL, 32'h2C);
    io2_in <= 1'h1;
    tick(2);
    chk("wake_io2", pme_oe, 1'h1);
    io2_in <= 1'h0;
    wr(`DMS_ADDR_PMDATA, 32'h1234_5678);
    rd(`DMS_ADDR_PMDATA, d, r);
    chk("pmdata", d, 32'h1234_5678);
    rd_stall(`DMS_ADDR_PMDATA, d);
    chk("pmdata_stall", d, 32'h1234_5678);
    rd(`DMS_ADDR_ACCESS, d, r);
    chk("access", d, 32'h0005_0410);
    rd(8'h20, d, r);
    chk("unmapped_resp", r, `DMS_RESP_SLVERR);
    chk("unmapped_data", d, 32'h0);
  endtask : t_pm
  task automatic t_d3cold;
    for (int k = 0; k < 2; k++) begin
      rst_to(3'h4, k == 0);
      wr(`DMS_ADDR_CTRL, 32'h22);
      modem_n <= 4'hE;
      tick(2);
      modem_n <= 4'hF;
      d3cold <= 1'h1;
      tick(2);
      chk("d3cold_keep", pme_oe, k == 0);
      d3cold <= 1'h0;
    end
  endtask : t_d3cold
  task automatic t_sub_ee;
    logic [31:0] d; logic [1:0] r;
    rst_to(3'h2, 1'h0);
    subsys_pins <= 32'hA5C3_0F96;
    tick(2);
    rd(`DMS_ADDR_SUBSYS, d, r);
    chk("subsys", d, 32'hA5C3_0F96);
    rst_to(3'h4, 1'h0);
    ee_zone <= 3'h5; go <= 1'h1;
    tick(1);
    go <= 1'h0;
    tick(10);
    chk("ee_ovr", {ee_overrun, ee_busy}, 2'h2);
    rd(`DMS_ADDR_STATUS, d, r);
    chk("zone_ok", d[10], 1'h0);
    rst_to(3'h1, 1'h0);
    ee_with_last <= 1'h1;
    go <= 1'h1;
    tick(1);
    go <= 1'h0;
    tick(10);
    chk("ee_done", {ee_overrun, ee_busy}, 2'h0);
    rd(`DMS_ADDR_STATUS, d, r);
    chk("zone_bad", d[10], 1'h1);
    ee_with_last <= 1'h0;
  endtask : t_sub_ee
  ////////////////////////////////////////
  initial begin
    tick(20000);
    miscompares++;
    conclude();
  end
  initial begin
    t_modes();
    t_hold_irq();
    t_pm();
    t_d3cold();
    t_sub_ee();
    conclude();
  end
endmodule : tb
